//--- design/dio_defs.vh
// Constants for the discrete I/O function block: register offsets,
// field positions, reset values and debounce timing.
// Assumes inclusion by bare name from design files.
`ifndef DIO_DEFS_VH
`define DIO_DEFS_VH

// Register byte offsets
`define DIO_OFF_CFG      12'h000
`define DIO_OFF_FUNC     12'h004
`define DIO_OFF_DEB      12'h008
`define DIO_OFF_STATUS   12'h00C
`define DIO_OFF_IRQ_STAT 12'h010
`define DIO_OFF_IRQ_MASK 12'h014

// Configuration register fields
`define DIO_CFG_RING_NO  0
`define DIO_CFG_WARN_NO  1
`define DIO_CFG_MUTE_NO  2
`define DIO_CFG_RS_HIGH  3
`define DIO_CFG_IGN_LOW  4
`define DIO_CFG_W        5
`define DIO_CFG_RESET    5'h00

// Function enable register: one bit per line, all on at reset
`define DIO_FUNC_W       5
`define DIO_FUNC_RESET   5'h1F

// Debounce time in ns and derived cycle count at 8 ns clock
`define DIO_CLK_NS       8
`define DIO_DEB_NS       1000
`define DIO_DEB_CYC      ((`DIO_DEB_NS + `DIO_CLK_NS - 1) / `DIO_CLK_NS)
`define DIO_DEB_W        16
// Reset debounce period: DIO_DEB_CYC held at the register width
`define DIO_DEB_RESET    16'h007D

// Status / interrupt bits
`define DIO_ST_RS        0
`define DIO_ST_IGN       1
`define DIO_ST_W         2
`define DIO_EV_RS_ON     0
`define DIO_EV_RS_OFF    1
`define DIO_EV_IGN_ON    2
`define DIO_EV_IGN_OFF   3
`define DIO_EV_W         4

`endif

//--- design/dio_debounce.v
// Synchroniser and debouncer for one discrete input line.
// Assumes a single clock; period count comes from a register.
`timescale 1ns/100ps
`default_nettype none
`include "dio_defs.vh"

module dio_debounce (
  // Clock and reset
  input  wire                  pclk,
  input  wire                  presetn,
  // Raw line and period
  input  wire                  raw_in,
  input  wire [`DIO_DEB_W-1:0] period,
  // Debounced level
  output reg                   level
);

  reg                  sync_a;
  reg                  sync_b;
  reg [`DIO_DEB_W-1:0] count;

  // Two-stage synchroniser, first stage read only by second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // Level accepted after it stays stable for the period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {`DIO_DEB_W{1'b0}};
      level <= 1'b0;
    end else if (sync_b == level) begin
      count <= {`DIO_DEB_W{1'b0}};
    end else if (count >= period) begin
      level <= sync_b;
      count <= {`DIO_DEB_W{1'b0}};
    end else begin
      count <= count + 16'h0001;
    end
  end

endmodule // dio_debounce
`default_nettype wire

//--- design/dio_func_logic.v
// Discrete I/O function logic: three switch-to-ground outputs and three
// debounced inputs, configured and observed over APB.
// Assumes pins are synchronous-level sensed; switch drivers external.
//
// Summary of operation
// [R1] Resting-closed ringer opens during incoming call
// [R2] Resting-open ringer grounds during incoming call
// [R3] Resting-closed warning opens while any alarm
// [R4] Resting-open warning grounds while any alarm
// [R5] Resting-closed mute opens during phone call
// [R6] Resting-open mute grounds during phone call
// [R7] Radio silence closes links, deregisters, blocks transmit
// [R8] Radio silence polarity selectable, default active low
// [R9] Active-high ignition follows DC-in voltage
// [R10] Active-low ignition follows grounded sense line; the code also requires DC-in present
// [R11] Ignition off enters standby, on restores
// [R12] Each line's function and polarity are configurable
// [R13] Inputs synchronised and debounced, configurable period
// [R14] Reset defaults: closed, active low, active high
`timescale 1ns/100ps
`default_nettype none
`include "dio_defs.vh"

module dio_func_logic (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Terminal call and alarm state
  input  wire        call_incoming,
  input  wire        alarm_active,
  input  wire        call_active,
  // Discrete pins: high means switch closed to ground
  output reg         ring_sw_closed,
  output reg         warn_sw_closed,
  output reg         mute_sw_closed,
  // Discrete input lines: high means line grounded, except dc_in_present where high means supply present
  input  wire        rs_pin_grounded,
  input  wire        ign_sense_grounded,
  input  wire        dc_in_present,
  // Terminal control
  output reg         radio_silence,
  output reg         close_links,
  output reg         deregister,
  output reg         tx_block,
  output reg         standby,
  // Interrupt
  output wire        irq
);

  reg [`DIO_CFG_W-1:0]  cfg;
  reg [`DIO_FUNC_W-1:0] func_en;
  reg [`DIO_DEB_W-1:0]  deb_period;
  reg [`DIO_EV_W-1:0]   irq_stat;
  reg [`DIO_EV_W-1:0]   irq_mask;
  reg                   rs_prev;
  reg                   ign_prev;
  reg [`DIO_EV_W-1:0]   next_irq_stat;
  wire                  rs_level;
  wire                  ign_s_level;
  wire                  dc_absent;
  wire                  dc_level;
  wire                  rs_on;
  wire                  ign_on;
  wire [`DIO_EV_W-1:0]  events;
  wire                  wr;
  wire                  rd;

  // Switch state from request and resting setting
  function sw_closed;
    input active;
    input rest_open;
    begin
      sw_closed = active ? rest_open : ~rest_open;
    end
  endfunction

  // Bus strobes; single-cycle access phase
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Input conditioning
  dio_debounce u_deb_rs (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (rs_pin_grounded),
    .period  (deb_period),
    .level   (rs_level)
  ); // see [R13]
  dio_debounce u_deb_ign (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (ign_sense_grounded),
    .period  (deb_period),
    .level   (ign_s_level)
  ); // see [R13]
  dio_debounce u_deb_dc (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (~dc_in_present),
    .period  (deb_period),
    .level   (dc_absent)
  ); // see [R13]

  // DC-in conditioned inverted: reset level means supply present, no false standby
  assign dc_level = ~dc_absent;

  // Asserted state of the inputs under selected polarity
  assign rs_on  = func_en[3] &
                  (cfg[`DIO_CFG_RS_HIGH] ? ~rs_level : rs_level); // see [R8]
  assign ign_on = ~func_en[4] |
                  (cfg[`DIO_CFG_IGN_LOW] ? (ign_s_level & dc_level)  // see [R10]
                                         : dc_level);               // see [R9]

  // Configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg        <= `DIO_CFG_RESET; // see [R14]
      func_en    <= `DIO_FUNC_RESET;
      deb_period <= `DIO_DEB_RESET;
      irq_mask   <= {`DIO_EV_W{1'b0}};
    end else if (wr) begin
      case (paddr)
        `DIO_OFF_CFG:      cfg        <= pwdata[`DIO_CFG_W-1:0];  // see [R12]
        `DIO_OFF_FUNC:     func_en    <= pwdata[`DIO_FUNC_W-1:0]; // see [R12]
        `DIO_OFF_DEB:      deb_period <= pwdata[`DIO_DEB_W-1:0];  // see [R13]
        `DIO_OFF_IRQ_MASK: irq_mask   <= pwdata[`DIO_EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Outputs from call, alarm and call-active requests
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_sw_closed <= 1'b1;
      warn_sw_closed <= 1'b1;
      mute_sw_closed <= 1'b1;
    end else begin
      ring_sw_closed <= sw_closed(func_en[0] & call_incoming,
                                  cfg[`DIO_CFG_RING_NO]); // see [R1] [R2]
      warn_sw_closed <= sw_closed(func_en[1] & alarm_active,
                                  cfg[`DIO_CFG_WARN_NO]); // see [R3] [R4]
      mute_sw_closed <= sw_closed(func_en[2] & call_active,
                                  cfg[`DIO_CFG_MUTE_NO]); // see [R5] [R6]
    end
  end

  // Radio silence and ignition control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio_silence <= 1'b0;
      close_links   <= 1'b0;
      deregister    <= 1'b0;
      tx_block      <= 1'b0;
      standby       <= 1'b0;
      rs_prev       <= 1'b0;
      ign_prev      <= 1'b1;
    end else begin
      rs_prev       <= rs_on;
      ign_prev      <= ign_on;
      radio_silence <= rs_on;
      close_links   <= rs_on & ~rs_prev; // see [R7]
      deregister    <= rs_on & ~rs_prev; // see [R7]
      tx_block      <= rs_on;            // see [R7]
      standby       <= ~ign_on;          // see [R11]
    end
  end

  assign events = {~ign_on & ign_prev, ign_on & ~ign_prev,
                   ~rs_on & rs_prev, rs_on & ~rs_prev};

  // Sticky status; read clears only bits returned, a new event wins
  always @* begin
    next_irq_stat = irq_stat;
    if (rd && paddr == `DIO_OFF_IRQ_STAT)
      next_irq_stat = irq_stat & ~prdata[`DIO_EV_W-1:0]; // Event at setup edge kept
    next_irq_stat = next_irq_stat | events;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_stat <= {`DIO_EV_W{1'b0}};
    else
      irq_stat <= next_irq_stat;
  end

  assign irq = |(irq_stat & irq_mask);

  // Read data mux, registered at the setup edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `DIO_OFF_CFG:      prdata <= {27'h0, cfg};
        `DIO_OFF_FUNC:     prdata <= {27'h0, func_en};
        `DIO_OFF_DEB:      prdata <= {16'h0, deb_period};
        `DIO_OFF_STATUS:   prdata <= {24'h0, mute_sw_closed, warn_sw_closed,
                                      ring_sw_closed, standby, tx_block,
                                      ign_on, rs_on, radio_silence};
        `DIO_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat};
        `DIO_OFF_IRQ_MASK: prdata <= {28'h0, irq_mask};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // dio_func_logic
`default_nettype wire

//--- tb/dio_field.sv
// Field model: radio silence switch and ignition wiring outside the terminal.
// Assumes the bench changes its requests just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module dio_field (
  // Clock and bench requests
  input  wire logic pclk,
  input  wire logic rs_on,
  input  wire logic rs_high,
  input  wire logic ign_on,
  input  wire logic ign_low,
  // Lines into the terminal
  output var  logic rs_pin_grounded,
  output var  logic ign_sense_grounded,
  output var  logic dc_in_present
);
  // Switch wiring follows the chosen polarity
  always @(posedge pclk) begin
    rs_pin_grounded    <= rs_on ^ rs_high;
    ign_sense_grounded <= ign_low ? ign_on : 1'b1;
    dc_in_present      <= ign_low ? 1'b1 : ign_on;
  end
endmodule // dio_field
`default_nettype wire

//--- tb/dio_func_logic_assertions.sv
// Checker for the discrete I/O block, bound to its top module.
// Assumes APB writes land at the access edge, switches follow one cycle late.
`timescale 1ns/100ps
`default_nettype none
module dio_chk (
  // Clock, reset, APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Requests and lines
  input wire logic        call_incoming,
  input wire logic        alarm_active,
  input wire logic        call_active,
  input wire logic        rs_pin_grounded,
  input wire logic        dc_in_present,
  // Outputs
  input wire logic        ring_sw_closed,
  input wire logic        warn_sw_closed,
  input wire logic        mute_sw_closed,
  input wire logic        radio_silence,
  input wire logic        close_links,
  input wire logic        deregister,
  input wire logic        tx_block,
  input wire logic        standby,
  input wire logic        irq
);
  logic [4:0] cfg;
  logic [4:0] fen;
  logic [3:0] mask;
  wire        wr = psel & penable & pwrite;
  // Shadow copies of configuration and interrupt mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg  <= 5'h00;
      fen  <= 5'h1F;
      mask <= 4'h0;
    end else if (wr && paddr == 12'h000) cfg <= pwdata[4:0];
    else if (wr && paddr == 12'h004) fen <= pwdata[4:0];
    else if (wr && paddr == 12'h014) mask <= pwdata[3:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RING: assert property (ring_sw_closed ==
    ~($past(cfg[0]) ^ ($past(fen[0]) & $past(call_incoming))))
    else $error("ring switch state wrong");
  AST_WARN: assert property (warn_sw_closed ==
    ~($past(cfg[1]) ^ ($past(fen[1]) & $past(alarm_active))))
    else $error("warning switch state wrong");
  AST_MUTE: assert property (mute_sw_closed ==
    ~($past(cfg[2]) ^ ($past(fen[2]) & $past(call_active))))
    else $error("mute switch state wrong");
  AST_TXB: assert property (tx_block == radio_silence)
    else $error("transmit block differs from silence");
  AST_PULSE: assert property (close_links |-> deregister ##1 !close_links)
    else $error("close and deregister pulse wrong");
  AST_RST: assert property ($rose(presetn) |-> !radio_silence && !standby && !tx_block)
    else $error("control outputs not idle after reset");
  AST_IRQ: assert property (mask == 4'h0 |-> !irq)
    else $error("interrupt while all masked");
  AST_STBY: assert property (
    $fell(standby) && !$past(cfg[4]) && $past(fen[4]) |-> $past(dc_in_present, 4))
    else $error("standby left without steady supply");
  AST_RS: assert property (
    $rose(radio_silence) && !$past(cfg[3]) |-> $past(rs_pin_grounded, 4))
    else $error("silence entered without steady ground");
  // Main scenarios reached
  cover property ($rose(radio_silence));
  cover property ($fell(standby));
  cover property ($rose(irq));
endmodule // dio_chk
bind dio_func_logic dio_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .call_incoming, .alarm_active, .call_active, .rs_pin_grounded, .dc_in_present,
  .ring_sw_closed, .warn_sw_closed, .mute_sw_closed, .radio_silence, .close_links,
  .deregister, .tx_block, .standby, .irq);
`default_nettype wire

//--- tb/testbench.sv
// Bench for the discrete I/O block: APB tasks, random call requests, field model.
// Assumes one 125 MHz clock; debounce period is set to 2 cycles.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, seed = 32'h2DBA08CD;
  logic        call_incoming = 0, alarm_active = 0, call_active = 0;
  logic        rs_on = 0, rs_high = 0, ign_on = 1, ign_low = 0;
  logic [2:0]  r, e, s, q[$];
  wire         rs_pin_grounded, ign_sense_grounded, dc_in_present, pready, pslverr, irq;
  wire         ring_sw_closed, warn_sw_closed, mute_sw_closed, radio_silence;
  wire         close_links, deregister, tx_block, standby;
  wire  [31:0] prdata;
  int          n_fail = 0, comparisons = 0, cyc = 0, i;
  dio_func_logic dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .call_incoming, .alarm_active, .call_active, .ring_sw_closed,
    .warn_sw_closed, .mute_sw_closed, .rs_pin_grounded, .ign_sense_grounded, .dc_in_present,
    .radio_silence, .close_links, .deregister, .tx_block, .standby, .irq);
  dio_field fld_u (.pclk, .rs_on, .rs_high, .ign_on, .ign_low, .rs_pin_grounded,
    .ign_sense_grounded, .dc_in_present);
  // Clock and hang guard
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      end_of_test;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(pslverr), 32'h0);
  endtask
  task end_of_test;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h1F);
    rchk(12'h008, 32'h7D);
    rchk(12'h00C, 32'hE4);
    apb(1'b1, 12'h01C, 32'hFF);
    rchk(12'h01C, 32'h0);
    apb(1'b1, 12'h008, 32'h2);
    // Every rest-state mix with random requests, model from a queue
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h000, 32'(c));
      rchk(12'h000, 32'(c));
      q = {{call_incoming, alarm_active, call_active}};
      repeat (40) begin
        @(posedge pclk);
        seed = xs(seed);
        {call_incoming, alarm_active, call_active} <= seed[2:0];
        q.push_back(seed[2:0]);
        // Compare mid-cycle, once the switches have settled
        @(negedge pclk);
        r = q.pop_front();
        e = ~({c[0], c[1], c[2]} ^ r);
        s = {ring_sw_closed, warn_sw_closed, mute_sw_closed};
        chk(32'(s), 32'(e));
      end
    end
    // Radio silence in both polarities, one-cycle glitch first
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, 12'h000, 32'(p << 3));
      rs_high <= p[0];
      repeat (10) @(posedge pclk);
      rs_on <= 1'b1;
      @(posedge pclk) rs_on <= 1'b0;
      repeat (20) @(posedge pclk);
      chk(32'(radio_silence), 32'h0);
      rs_on <= 1'b1;
      for (i = 0; i < 60 && radio_silence !== 1'b1; i++) @(posedge pclk);
      chk(32'({radio_silence, tx_block, close_links, deregister}), 32'hF);
      rs_on <= 1'b0;
      for (i = 0; i < 60 && radio_silence !== 1'b0; i++) @(posedge pclk);
      chk(32'({radio_silence, tx_block, close_links, deregister}), 32'h0);
    end
    // Ignition in both wirings: off gives standby, on restores
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, 12'h000, 32'(p << 4));
      rs_high <= 1'b0;
      ign_low <= p[0];
      ign_on  <= 1'b0;
      for (i = 0; i < 60 && standby !== 1'b1; i++) @(posedge pclk);
      chk(32'(standby), 32'h1);
      ign_on <= 1'b1;
      for (i = 0; i < 60 && standby !== 1'b0; i++) @(posedge pclk);
      chk(32'(standby), 32'h0);
    end
    // Function bits clear: outputs rest, both inputs ignored
    apb(1'b1, 12'h004, 32'h0);
    {call_incoming, alarm_active, call_active} <= 3'h7;
    rs_on  <= 1'b1;
    ign_on <= 1'b0;
    repeat (20) @(posedge pclk);
    s = {ring_sw_closed, warn_sw_closed, mute_sw_closed};
    chk(32'({s, radio_silence, standby}), 32'h1C);
    {call_incoming, alarm_active, call_active} <= 3'h0;
    rs_on  <= 1'b0;
    ign_on <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h004, 32'h1F);
    rchk(12'h004, 32'h1F);
    // Interrupt: only ignition-on unmasked, read clears
    apb(1'b0, 12'h010, 32'h0);
    apb(1'b1, 12'h014, 32'h4);
    ign_on <= 1'b0;
    for (i = 0; i < 60 && standby !== 1'b1; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    ign_on <= 1'b1;
    for (i = 0; i < 60 && standby !== 1'b0; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rchk(12'h010, 32'hC);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rchk(12'h010, 32'h0);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
